//--- rtl/ais_input_select.sv
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module ais_input_select
  import ais_pkg::*;
#(
  parameter logic [AIS_NUM_IN-1:0] INPUT_PRESENT = AIS_ALL_IN
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic [2:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire logic                  sample_start,
  output logic      [AIS_IDX_W-1:0]  sel_pos_idx,
  output logic                       sel_pos_valid,
  output logic                       sel_low_reference_level,
  output logic                       sel_neg_an1,
  output logic                       sel_phase_b,
  output logic      [AIS_NUM_IN-1:0] pin_digital,
  output logic      [AIS_NUM_IN-1:0] pin_read_en,
  output logic      [AIS_NUM_IN-1:0] mux_tie_gnd
);

  logic [15:0]           chsel_q;
  logic [15:0]           scan_q;
  logic [15:0]           pcfg_q;
  logic [15:0]           ctrl_q;
  logic [15:0]           rdata_q;
  ais_phase_t            phase_q;
  ais_phase_t            phase_d;
  logic [AIS_IDX_W-1:0]  ptr_q;
  logic [AIS_IDX_W-1:0]  ptr_d;
  logic [AIS_IDX_W-1:0]  ptr_next;
  logic [AIS_IDX_W-1:0]  pos_idx_q;
  logic                  pos_valid_q;
  logic                  low_reference_level_q;
  logic                  neg_an1_q;
  logic                  phase_b_q;
  logic [AIS_NUM_IN-1:0] pin_dig_q;

  // address decode
  wire wr_chsel = reg_wr && (reg_addr == AIS_ADDR_CHSEL);
  wire wr_scan  = reg_wr && (reg_addr == AIS_ADDR_SCAN);
  wire wr_pcfg  = reg_wr && (reg_addr == AIS_ADDR_PCFG);
  wire wr_ctrl  = reg_wr && (reg_addr == AIS_ADDR_CTRL);

  // control bits
  wire alt_on  = ctrl_q[AIS_CTRL_ALT_BIT];
  wire scan_on = ctrl_q[AIS_CTRL_SCAN_BIT];
  wire mod_dis = ctrl_q[AIS_CTRL_DIS_BIT];

  // which selection set applies to the coming sample
  wire use_b = alt_on && (phase_q == AIS_PH_B);
  wire scan_now = scan_on && !use_b;

  // positive and negative selection for the coming sample
  wire [AIS_POS_W-1:0] code_a = chsel_q[AIS_POS_A_LSB +: AIS_POS_W];
  wire [AIS_POS_W-1:0] code_b = chsel_q[AIS_POS_B_LSB +: AIS_POS_W];
  wire [AIS_POS_W-1:0] code_s = {1'b0, ptr_q};
  wire [AIS_POS_W-1:0] pos_code = use_b ? code_b : (scan_now ? code_s : code_a);
  wire neg_sel = use_b ? chsel_q[AIS_NEG_B_BIT] : chsel_q[AIS_NEG_A_BIT];

  // reserved codes: past the last input, or an input the package lacks
  wire code_in_range = (pos_code <= AIS_MAX_CODE);
  wire [AIS_IDX_W-1:0] pos_idx = pos_code[AIS_IDX_W-1:0];
  wire input_here = code_in_range && INPUT_PRESENT[pos_idx];
  wire pos_valid = input_here;
  wire low_reference_level_now = scan_now && !input_here;

  // scan helper signals, also used by the checks
  wire ptr_member = scan_q[ptr_q];
  wire ptr_present = INPUT_PRESENT[ptr_q];
  logic scan_any;
  logic [AIS_IDX_W-1:0] ptr_first;

  ais_scan_next #(
    .NUM_IN (AIS_NUM_IN),
    .IDX_W  (AIS_IDX_W)
  ) u_scan_next (
    .mask     (scan_q[AIS_NUM_IN-1:0]),
    .cur_idx  (ptr_q),
    .next_idx (ptr_next),
    .any_set  (scan_any)
  );

  // lowest member: nothing lies above an all-ones pointer, so it wraps
  ais_scan_next #(
    .NUM_IN (AIS_NUM_IN),
    .IDX_W  (AIS_IDX_W)
  ) u_scan_first (
    .mask     (scan_q[AIS_NUM_IN-1:0]),
    .cur_idx  ({AIS_IDX_W{1'b1}}),
    .next_idx (ptr_first),
    .any_set  ()
  );

  // absent inputs and a disabled module leave the pin digital
  wire [AIS_NUM_IN-1:0] pin_dig_d = mod_dis ? AIS_ALL_IN
                                    : (pcfg_q[AIS_NUM_IN-1:0] | ~INPUT_PRESENT);

  // read mux, reserved bits come back zero
  logic [15:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      AIS_ADDR_CHSEL: rd_mux = chsel_q & AIS_CHSEL_IMPL;
      AIS_ADDR_SCAN:  rd_mux = scan_q & AIS_SCAN_IMPL;
      AIS_ADDR_PCFG:  rd_mux = pcfg_q & AIS_PCFG_IMPL;
      AIS_ADDR_CTRL:  rd_mux = ctrl_q & AIS_CTRL_IMPL;
      AIS_ADDR_STAT: begin
        rd_mux = 16'h0000;
        rd_mux[AIS_STAT_PH_BIT] = (phase_q == AIS_PH_B);
        rd_mux[AIS_STAT_PTR_LSB +: AIS_IDX_W] = ptr_q;
      end
      default:        rd_mux = 16'h0000;
    endcase
  end

  // alternation: without the alternate bit the phase rests on A
  always_comb begin
    phase_d = phase_q;
    if (!alt_on) begin
      phase_d = AIS_PH_A;
    end else if (sample_start) begin
      unique case (phase_q)
        AIS_PH_A: phase_d = AIS_PH_B;
        AIS_PH_B: phase_d = AIS_PH_A;
        default:  phase_d = AIS_PH_A;
      endcase
    end
  end

  // pointer rests on the first member while scanning is off,
  // so the first scanned sample starts at the lowest member
  always_comb begin
    ptr_d = ptr_q;
    if (!scan_on) begin
      ptr_d = scan_any ? ptr_first : ptr_q;
    end else if (sample_start && !use_b && scan_any) begin
      ptr_d = ptr_next;
    end
  end

  // software registers, unimplemented bits never stored
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chsel_q <= AIS_CHSEL_RST;
      scan_q  <= AIS_SCAN_RST;
      pcfg_q  <= AIS_PCFG_RST;
      ctrl_q  <= AIS_CTRL_RST;
    end else begin
      if (wr_chsel) chsel_q <= reg_wdata & AIS_CHSEL_IMPL;
      if (wr_scan)  scan_q  <= reg_wdata & AIS_SCAN_IMPL;
      if (wr_pcfg)  pcfg_q  <= reg_wdata & AIS_PCFG_IMPL;
      if (wr_ctrl)  ctrl_q  <= reg_wdata & AIS_CTRL_IMPL;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // sample sequencing state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= AIS_PH_A;
      ptr_q   <= '0;
    end else begin
      phase_q <= phase_d;
      ptr_q   <= ptr_d;
    end
  end

  // selection held for the whole sample, changes only at its start
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_idx_q   <= '0;
      pos_valid_q <= 1'b0;
      low_reference_level_q     <= 1'b0;
      neg_an1_q   <= 1'b0;
      phase_b_q   <= 1'b0;
    end else if (sample_start) begin
      pos_idx_q   <= pos_idx;
      pos_valid_q <= pos_valid;
      low_reference_level_q     <= low_reference_level_now;
      neg_an1_q   <= neg_sel;
      phase_b_q   <= use_b;
    end
  end

  // pin mode, registered to keep pad controls glitch free
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_dig_q <= ~INPUT_PRESENT;
    end else begin
      pin_dig_q <= pin_dig_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign sel_pos_idx   = pos_idx_q;
  assign sel_pos_valid = pos_valid_q;
  assign sel_low_reference_level     = low_reference_level_q;
  assign sel_neg_an1   = neg_an1_q;
  assign sel_phase_b   = phase_b_q;
  // digital pins read through and ground the converter mux
  assign pin_digital   = pin_dig_q;
  assign pin_read_en   = pin_dig_q;
  assign mux_tie_gnd   = pin_dig_q;

  // checks on the selection path, the register reads and the pin modes
  a_neg_b_route: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sample_start && use_b |=> sel_neg_an1 == $past(chsel_q[AIS_NEG_B_BIT]))
    else $error("sample B negative select wrong");

  a_pos_b_route: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sample_start && use_b
    |=> sel_pos_idx == $past(chsel_q[AIS_POS_B_LSB +: AIS_IDX_W]) && sel_phase_b)
    else $error("sample B positive select wrong");

  a_neg_a_route: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sample_start && !use_b |=> sel_neg_an1 == $past(chsel_q[AIS_NEG_A_BIT]))
    else $error("sample A negative select wrong");

  a_pos_a_fixed: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sample_start && !use_b && !scan_on
    |=> sel_pos_idx == $past(chsel_q[AIS_POS_A_LSB +: AIS_IDX_W]))
    else $error("sample A positive select wrong");

  a_chsel_unimpl: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_rd && reg_addr == AIS_ADDR_CHSEL |=> (reg_rdata & ~AIS_CHSEL_IMPL) == 16'h0000)
    else $error("unimplemented select bits read nonzero");

  a_mask_discard: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    wr_scan ##1 reg_rd && reg_addr == AIS_ADDR_SCAN |=> reg_rdata[15:13] == 3'h0)
    else $error("write to unimplemented mask bits kept");

  a_scan_member: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sample_start && scan_now && ptr_member && !wr_scan
    |=> sel_pos_idx == $past(ptr_q) && scan_q[ptr_q])
    else $error("scan picked a non-member input");

  a_scan_low_reference_level: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sample_start && scan_now && !ptr_present |=> sel_low_reference_level && !sel_pos_valid)
    else $error("absent scanned input not on low reference");

  a_ptr_rest: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !scan_on && scan_any |=> ptr_q == $past(ptr_first))
    else $error("scan pointer not on lowest member");

  a_reserved_code: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sample_start && !code_in_range |=> !sel_pos_valid && !sel_low_reference_level)
    else $error("reserved code gave a valid input");

  a_pin_disable: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    mod_dis |=> pin_digital == AIS_ALL_IN && mux_tie_gnd == AIS_ALL_IN)
    else $error("disabled module left a pin analog");

  a_pin_config: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !mod_dis |=> pin_read_en == $past(pcfg_q[AIS_NUM_IN-1:0] | ~INPUT_PRESENT))
    else $error("pin mode does not follow configuration");

  a_alt_toggle: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sample_start && alt_on && phase_q == AIS_PH_A && !wr_ctrl
    |=> phase_q == AIS_PH_B && !sel_phase_b)
    else $error("alternate sampling did not swap");

  a_no_alt_rest: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !alt_on |=> phase_q == AIS_PH_A)
    else $error("phase left A without alternate bit");

endmodule : ais_input_select

//--- rtl/ais_pkg.sv
package ais_pkg;

  // register word offsets on the plain register port
  localparam logic [2:0] AIS_ADDR_CHSEL = 3'h0;
  localparam logic [2:0] AIS_ADDR_SCAN  = 3'h1;
  localparam logic [2:0] AIS_ADDR_PCFG  = 3'h2;
  localparam logic [2:0] AIS_ADDR_CTRL  = 3'h3;
  localparam logic [2:0] AIS_ADDR_STAT  = 3'h4;

  // implemented-bit masks, everything else reads zero
  localparam logic [15:0] AIS_CHSEL_IMPL = 16'h9f9f;
  localparam logic [15:0] AIS_SCAN_IMPL  = 16'h1fff;
  localparam logic [15:0] AIS_PCFG_IMPL  = 16'h1fff;
  localparam logic [15:0] AIS_CTRL_IMPL  = 16'h0007;

  // values after reset
  localparam logic [15:0] AIS_CHSEL_RST = 16'h0000;
  localparam logic [15:0] AIS_SCAN_RST  = 16'h0000;
  localparam logic [15:0] AIS_PCFG_RST  = 16'h0000;
  localparam logic [15:0] AIS_CTRL_RST  = 16'h0000;

  // channel-0 select fields
  localparam int AIS_NEG_B_BIT = 15;
  localparam int AIS_POS_B_LSB = 8;
  localparam int AIS_NEG_A_BIT = 7;
  localparam int AIS_POS_A_LSB = 0;
  localparam int AIS_POS_W     = 5;

  // control and status fields
  localparam int AIS_CTRL_ALT_BIT  = 0;
  localparam int AIS_CTRL_SCAN_BIT = 1;
  localparam int AIS_CTRL_DIS_BIT  = 2;
  localparam int AIS_STAT_PH_BIT   = 0;
  localparam int AIS_STAT_PTR_LSB  = 8;

  // inputs and index width
  localparam int             AIS_NUM_IN   = 13;
  localparam int             AIS_IDX_W    = 4;
  localparam logic [4:0]     AIS_MAX_CODE = 5'h0c;
  localparam logic [12:0]    AIS_ALL_IN   = 13'h1fff;

  typedef enum logic [1:0] {
    AIS_PH_A = 2'b01,
    AIS_PH_B = 2'b10
  } ais_phase_t;

endpackage : ais_pkg

//--- rtl/ais_scan_next.sv
`timescale 1ns/1ps
module ais_scan_next
  import ais_pkg::*;
#(
  parameter int NUM_IN = AIS_NUM_IN,
  parameter int IDX_W  = AIS_IDX_W
) (
  input  wire logic [NUM_IN-1:0] mask,
  input  wire logic [IDX_W-1:0]  cur_idx,
  output logic      [IDX_W-1:0]  next_idx,
  output logic                   any_set
);

  logic [NUM_IN-1:0] above;

  // members strictly above the current pointer
  for (genvar i = 0; i < NUM_IN; i++) begin : g_above
    assign above[i] = mask[i] & (IDX_W'(i) > cur_idx);
  end

  // lowest member above, else wrap to the lowest member overall
  always_comb begin
    next_idx = cur_idx;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (mask[i]) begin
        next_idx = IDX_W'(i);
      end
    end
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (above[i]) begin
        next_idx = IDX_W'(i);
      end
    end
  end

  assign any_set = |mask;

endmodule : ais_scan_next

//--- verification/tb_ais_input_select.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_ais_input_select
  import ais_pkg::*;
;
  // 28-pin variant: inputs 6..8 absent, exercises the ignore paths
  localparam logic [12:0] PRESENT = 13'h1e3f;

  logic                  ref_clk;
  logic                  sys_rst;
  logic [2:0]            reg_addr;
  logic [15:0]           reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [15:0]           reg_rdata;
  logic                  sample_start;
  logic [AIS_IDX_W-1:0]  sel_pos_idx;
  logic                  sel_pos_valid;
  logic                  sel_low_reference_level;
  logic                  sel_neg_an1;
  logic                  sel_phase_b;
  logic [AIS_NUM_IN-1:0] pin_digital;
  logic [AIS_NUM_IN-1:0] pin_read_en;
  logic [AIS_NUM_IN-1:0] mux_tie_gnd;
  int                    fails;
  int                    checks_done;
  logic [31:0]           rng;
  int                    members[$];

  ais_input_select #(.INPUT_PRESENT(PRESENT)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_start(sample_start),
    .sel_pos_idx(sel_pos_idx), .sel_pos_valid(sel_pos_valid), .sel_low_reference_level(sel_low_reference_level),
    .sel_neg_an1(sel_neg_an1), .sel_phase_b(sel_phase_b), .pin_digital(pin_digital),
    .pin_read_en(pin_read_en), .mux_tie_gnd(mux_tie_gnd));

  // 8 ns period
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // one-cycle write strobe, register updated at the taking edge
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : rd

  // write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [2:0] a, input logic [15:0] d, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge ref_clk);
    reg_rd    <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : wr_rd

  task automatic smp();
    @(posedge ref_clk);
    sample_start <= 1'b1;
    @(posedge ref_clk);
    sample_start <= 1'b0;
    #1;
  endtask : smp

  // absent inputs and module disable both force digital mode
  task automatic chk_pins(input logic [15:0] cfg, input logic dis);
    logic [12:0] e;
    e = dis ? 13'h1fff : (cfg[12:0] | ~PRESENT);
    `CHK("pin_digital", e, pin_digital)
    `CHK("pin_read_en", e, pin_read_en)
    `CHK("mux_tie_gnd", e, mux_tie_gnd)
  endtask : chk_pins

  // a code names a real input only up to 12 and when present
  task automatic chk_pos(input int code, input logic neg, input logic ph);
    logic v;
    v = (code <= 12) && PRESENT[code % 13];
    `CHK("sel_pos_valid", v, sel_pos_valid)
    if (v) `CHK("sel_pos_idx", code[AIS_IDX_W-1:0], sel_pos_idx)
    `CHK("sel_neg_an1", neg, sel_neg_an1)
    `CHK("sel_phase_b", ph, sel_phase_b)
    `CHK("sel_low_reference_level", 1'b0, sel_low_reference_level)
  endtask : chk_pos

  // hang guard, far above the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    conclude();
  end

  initial begin
    logic [15:0] d;
    logic [15:0] m;
    logic [2:0]  a;
    int          k;
    rng          = 32'd58;
    fails        = 0;
    checks_done  = 0;
    sys_rst      = 1'b1;
    reg_addr     = 3'h0;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    sample_start = 1'b0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // reset state of every register and of the pins
    for (int i = 0; i < 8; i++) rd(i[2:0], 16'h0000);
    chk_pins(16'h0000, 1'b0);
    wr(AIS_ADDR_STAT, 16'hffff);
    rd(AIS_ADDR_STAT, 16'h0000);
    // random words, unimplemented bits and unmapped places read zero
    for (int i = 0; i < 24; i++) begin
      d = 16'(xs());
      a = 3'(i % 8);
      m = (a == AIS_ADDR_CHSEL) ? AIS_CHSEL_IMPL : (a == AIS_ADDR_SCAN) ? AIS_SCAN_IMPL :
          (a == AIS_ADDR_PCFG) ? AIS_PCFG_IMPL : 16'h0000;
      if (a == AIS_ADDR_CTRL || a == AIS_ADDR_STAT) continue;
      if (i[0]) begin
        wr_rd(a, d, d & m);
      end else begin
        wr(a, d);
        rd(a, d & m);
      end
    end
    // pin modes follow config, then module disable overrides
    for (int i = 0; i < 4; i++) begin
      d = 16'(xs());
      wr(AIS_ADDR_PCFG, d);
      @(posedge ref_clk);
      #1;
      chk_pins(d, 1'b0);
    end
    wr(AIS_ADDR_CTRL, 16'h0004);
    @(posedge ref_clk);
    #1;
    chk_pins(d, 1'b1);
    // every code in both fields, alternating A then B
    wr(AIS_ADDR_CTRL, 16'h0001);
    for (int c = 0; c < 32; c++) begin
      d = {~c[0], 2'b00, 5'(31 - c), c[0], 2'b00, 5'(c)};
      wr(AIS_ADDR_CHSEL, d);
      smp();
      chk_pos(c, c[0], 1'b0);
      smp();
      chk_pos(31 - c, ~c[0], 1'b1);
    end
    wr(AIS_ADDR_CTRL, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      smp();
      chk_pos(31, 1'b1, 1'b0);
    end
    // scan over members 2, 7, 8; 7 and 8 are absent
    wr(AIS_ADDR_CHSEL, 16'h0085);
    wr(AIS_ADDR_SCAN, 16'h0184);
    wr(AIS_ADDR_CTRL, 16'hfffa);
    rd(AIS_ADDR_CTRL, 16'h0002);
    members = '{2, 7, 8};
    for (int i = 0; i < 7; i++) begin
      smp();
      k = members[i % 3];
      `CHK("scan valid", PRESENT[k], sel_pos_valid)
      `CHK("scan low_reference_level", ~PRESENT[k], sel_low_reference_level)
      if (PRESENT[k]) `CHK("scan idx", 4'(k), sel_pos_idx)
      `CHK("scan neg", 1'b1, sel_neg_an1)
    end
    // seven samples end on member 2, so the pointer now waits on 7
    rd(AIS_ADDR_STAT, 16'h0700);
    conclude();
  end
endmodule : tb_ais_input_select
